// >>> src/lbha_arbiter.sv
// Purpose: Hold-request arbitration of one shared external local bus.
// Assumes: The external bus controller reports cycle activity and needs.
// Notes:   One clock; bus clock units come from an enable divider.
`timescale 1ns/1ns
`include "lbha_params.svh"

module lbha_arbiter
    import lbha_pkg::*;
#(
    parameter int UNIT_CYCLES = `LBHA_UNIT_CYCLES
)
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Configuration from the controller's own configuration logic.
    input  wire logic       arb_master_select,
    input  wire logic       hold_response_enable,
    // External bus controller status.
    input  wire logic       ext_access_needed,
    input  wire logic       ext_cycle_active,
    input  wire logic       ext_cycle_done,
    // Arbitration pins from the other controller.
    input  wire logic       hold_request_n,
    input  wire logic       hold_ack_n_in,
    // Arbitration pins to the other controller.
    output logic            hold_ack_n,
    output logic            hold_ack_oe,
    output logic            bus_request_n,
    // Bus drive controls.
    output logic            bus_drive_en,
    output logic            cmd_drive_en,
    output logic            bus_granted
);

    // ========================================================================
    // Synchronisers and bus clock unit divider
    // ========================================================================
    lbha_pins_in_s sync1;
    lbha_pins_in_s sync2;
    lbha_pins_in_s sync3;
    logic [15:0]   unit_cnt;
    logic          unit_tick;
    logic          hold_en_q;
    logic          hold_en_seen;
    logic [1:0]    glitch_cnt;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1 <= '1;
            sync2 <= '1;
            sync3 <= '1;
        end
        else
        begin
            sync1 <= '{hold_request_n, hold_ack_n_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    wire unit_wrap = (unit_cnt == 16'(UNIT_CYCLES - 1));

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            unit_cnt  <= 16'h0000;
            unit_tick <= 1'b0;
        end
        else
        begin
            unit_cnt  <= unit_wrap ? 16'h0000 : unit_cnt + 16'h0001;
            unit_tick <= unit_wrap;
        end
    end

    wire hreq_low     = !sync2.hold_request_n;
    wire hreq_rise    = sync2.hold_request_n && !sync3.hold_request_n;
    wire hreq_fall    = !sync2.hold_request_n && sync3.hold_request_n;
    wire hack_fall    = !sync2.hold_ack_n && sync3.hold_ack_n;
    wire both_high    = sync2.hold_request_n && sync2.hold_ack_n;

    // ========================================================================
    // Arbitration state machine
    // ========================================================================
    lbha_state_e state;
    lbha_state_e next_state;
    logic        cycle_seen;
    logic        hold_pending;
    logic [1:0]  hold_ticks;
    logic [15:0] regain_cnt;

    // Mode follows the bit directly; reset holds the bit low so slave wins.
    wire master_mode = (arb_master_select == `LBHA_MODE_MASTER);
    wire hold_en_rise = hold_response_enable && !hold_en_q;

    always_comb
    begin
        next_state = state;
        case (state)
            LBHA_IDLE:
                next_state = master_mode ? LBHA_M_RUN : LBHA_S_HOLD;
            LBHA_S_HOLD:
                if (master_mode)
                    next_state = LBHA_M_RUN;
                else if (ext_access_needed && hold_en_seen && sync2.hold_request_n)
                    next_state = LBHA_S_WAIT_ACK;
            LBHA_S_WAIT_ACK:
                if (hack_fall)
                    next_state = LBHA_S_OWN;
                else if (both_high && !ext_access_needed)
                    next_state = LBHA_S_HOLD;
            LBHA_S_OWN:
                // Requests seen while taking the bus are held back.
                if ((hold_pending || hreq_low) && cycle_seen && !ext_cycle_active)
                    next_state = LBHA_S_BACKOFF;
            LBHA_S_BACKOFF:
                next_state = LBHA_S_HOLD;
            LBHA_M_RUN:
                if (!master_mode)
                    next_state = LBHA_S_HOLD;
                else if (hreq_low && hold_response_enable)
                    next_state = LBHA_M_DRAIN;
            LBHA_M_DRAIN:
                if (!ext_cycle_active)
                    next_state = LBHA_M_HOLD;
            LBHA_M_HOLD:
                if (hreq_rise || sync2.hold_request_n)
                    next_state = LBHA_M_REGAIN;
            LBHA_M_REGAIN:
                if (regain_cnt == 16'(UNIT_CYCLES - 1))
                    next_state = LBHA_M_REQ_DROP;
            LBHA_M_REQ_DROP:
                next_state = LBHA_M_RUN;
            default:
                next_state = LBHA_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            state <= LBHA_IDLE;
        else
            state <= next_state;
    end

    // In slave mode, one whole external cycle must be seen before a hold request is honoured.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cycle_seen   <= 1'b0;
            hold_pending <= 1'b0;
        end
        else if (state != LBHA_S_OWN)
        begin
            cycle_seen   <= 1'b0;
            hold_pending <= 1'b0;
        end
        else
        begin
            cycle_seen   <= cycle_seen | ext_cycle_done;
            hold_pending <= hold_pending | hreq_fall | hreq_low;
        end
    end

    // Two ticks in hold prove that one whole unit has passed since the ack fell.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_ticks <= 2'b00;
            regain_cnt <= 16'h0000;
        end
        else
        begin
            if (state != LBHA_M_HOLD)
                hold_ticks <= 2'b00;
            else if (unit_tick && hold_ticks != 2'b10)
                hold_ticks <= hold_ticks + 2'b01;
            if (state != LBHA_M_REGAIN)
                regain_cnt <= 16'h0000;
            else
                regain_cnt <= regain_cnt + 16'h0001;
        end
    end

    // Hold enable edge in slave mode: the request line may dip for two units.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_en_q    <= `LBHA_HOLD_EN_RESET;
            hold_en_seen <= 1'b0;
            glitch_cnt   <= 2'b00;
        end
        else
        begin
            hold_en_q <= hold_response_enable;
            // In slave mode, pins stay arbitration pins once enabled, even after a clear.
            if (hold_response_enable)
                hold_en_seen <= 1'b1;
            if (hold_en_rise && !master_mode)
                glitch_cnt <= 2'(`LBHA_GLITCH_UNITS);
            else if (unit_tick && glitch_cnt != 2'b00)
                glitch_cnt <= glitch_cnt - 2'b01;
        end
    end

    // ========================================================================
    // Pin and drive outputs
    // ========================================================================
    wire s_req   = (state == LBHA_S_WAIT_ACK) || (state == LBHA_S_OWN) ||
                   (glitch_cnt != 2'b00);
    // A master that needs the bus in hold asks for it; the request stays through regain.
    wire m_req   = ((state == LBHA_M_HOLD) && ext_access_needed && (hold_ticks == 2'b10)) ||
                   ((state == LBHA_M_REGAIN) && !bus_request_n);
    wire m_ack   = (state == LBHA_M_HOLD);
    wire drive   = (state == LBHA_S_OWN) || (state == LBHA_M_RUN) ||
                   (state == LBHA_M_DRAIN) || (state == LBHA_M_REQ_DROP) ||
                   (state == LBHA_M_REGAIN);
    lbha_pins_out_s next_pins;
    assign next_pins = '{!m_ack, !(s_req || m_req), drive, drive};

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_ack_n    <= 1'b1;
            hold_ack_oe   <= 1'b0;
            bus_request_n <= 1'b1;
            bus_drive_en  <= 1'b0;
            cmd_drive_en  <= 1'b0;
            bus_granted   <= 1'b0;
        end
        else
        begin
            hold_ack_n    <= next_pins.hold_ack_n;
            hold_ack_oe   <= master_mode;
            bus_request_n <= next_pins.bus_request_n;
            bus_drive_en  <= next_pins.bus_drive_en;
            cmd_drive_en  <= next_pins.cmd_drive_en;
            bus_granted   <= drive;
        end
    end

endmodule

// >>> src/lbha_params.svh
// Purpose: Constants for the local bus hold arbiter.
// Assumes: One 250 MHz clock; one bus clock unit is a divider enable pulse.
// Notes:   Included by the arbiter top; the package does not include it.
`ifndef LBHA_PARAMS_SVH
`define LBHA_PARAMS_SVH
`define LBHA_CLK_PERIOD_PS     4000
`define LBHA_UNIT_PS_DEFAULT   16000
`define LBHA_UNIT_CYCLES       ((`LBHA_UNIT_PS_DEFAULT + `LBHA_CLK_PERIOD_PS - 1) / `LBHA_CLK_PERIOD_PS)
`define LBHA_GLITCH_UNITS      2
`define LBHA_MODE_SLAVE        1'b0
`define LBHA_MODE_MASTER       1'b1
`define LBHA_HOLD_EN_RESET     1'b0
`endif

// >>> src/lbha_pkg.sv
// Purpose: Types for the local bus hold arbiter.
// Assumes: Nothing beyond the params header.
// Notes:   Pin groups travel as packed structs.
package lbha_pkg;
    typedef enum logic [3:0]
    {
        LBHA_IDLE,
        LBHA_S_HOLD,
        LBHA_S_WAIT_ACK,
        LBHA_S_OWN,
        LBHA_S_BACKOFF,
        LBHA_M_RUN,
        LBHA_M_DRAIN,
        LBHA_M_HOLD,
        LBHA_M_REGAIN,
        LBHA_M_REQ_DROP
    } lbha_state_e;

    typedef struct packed
    {
        logic hold_request_n;
        logic hold_ack_n;
    } lbha_pins_in_s;

    typedef struct packed
    {
        logic hold_ack_n;
        logic bus_request_n;
        logic bus_drive_en;
        logic cmd_drive_en;
    } lbha_pins_out_s;
endpackage

// >>> testbench/lbha_arbiter_asserts.sv
// Purpose: Port assertions of the hold arbiter.
// Assumes: One clock domain.
// Notes:   Bound into every arbiter instance.
`timescale 1ns/1ns
// ==========================================================
// Checker
module lbha_arbiter_asserts #(parameter int UNIT_CYCLES = 4)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Inputs of the arbiter.
    input wire logic arb_master_select,
    input wire logic hold_response_enable,
    input wire logic hold_request_n,
    input wire logic hold_ack_n_in,
    // Outputs of the arbiter.
    input wire logic hold_ack_n,
    input wire logic hold_ack_oe,
    input wire logic bus_request_n,
    input wire logic bus_drive_en,
    input wire logic cmd_drive_en
);
    localparam int TMAX = UNIT_CYCLES + 2;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_s_oe; !arb_master_select [*3] |-> !hold_ack_oe; endproperty
    a_s_oe: assert property (p_s_oe) else $error("ack driven in slave mode");
    property p_s_hold;
        (!arb_master_select && hold_request_n && hold_ack_n_in) [*4] |-> !bus_drive_en;
    endproperty
    a_s_hold: assert property (p_s_hold) else $error("slave drives in hold");
    property p_s_go;
        !arb_master_select && !bus_request_n && $fell(hold_ack_n_in) |-> ##[1:8] bus_drive_en;
    endproperty
    a_s_go: assert property (p_s_go) else $error("slave not released");
    property p_s_off;
        !hold_ack_oe && $rose(bus_request_n) |-> !bus_drive_en && !cmd_drive_en;
    endproperty
    a_s_off: assert property (p_s_off) else $error("request dropped while driving");
    property p_m_rel;
        hold_ack_oe && $fell(hold_ack_n) |-> !bus_drive_en && !cmd_drive_en && bus_request_n;
    endproperty
    a_m_rel: assert property (p_m_rel) else $error("ack before release");
    property p_m_back; hold_ack_oe && $rose(hold_ack_n) |-> ##[0:2] bus_drive_en; endproperty
    a_m_back: assert property (p_m_back) else $error("master not driving");
    property p_m_req; hold_ack_oe && $rose(hold_ack_n) |-> ##[1:TMAX] bus_request_n; endproperty
    a_m_req: assert property (p_m_req) else $error("request not dropped");
    property p_m_ign;
        arb_master_select && !hold_response_enable && hold_ack_n |=> hold_ack_n;
    endproperty
    a_m_ign: assert property (p_m_ign) else $error("hold taken while disabled");
    property p_m_pin; arb_master_select [*4] |-> hold_ack_oe; endproperty
    a_m_pin: assert property (p_m_pin) else $error("ack pin not driven");
    c_m_hold: cover property (hold_ack_oe && $fell(hold_ack_n));
    c_s_own: cover property (!arb_master_select && $rose(bus_drive_en));
    c_m_off: cover property (arb_master_select && !hold_response_enable && !hold_request_n);
endmodule
bind lbha_arbiter lbha_arbiter_asserts #(.UNIT_CYCLES(UNIT_CYCLES)) i_lbha_arbiter_asserts
    (.clk(clk), .reset_n(reset_n), .arb_master_select(arb_master_select),
    .hold_response_enable(hold_response_enable), .hold_request_n(hold_request_n),
    .hold_ack_n_in(hold_ack_n_in), .hold_ack_n(hold_ack_n), .hold_ack_oe(hold_ack_oe),
    .bus_request_n(bus_request_n), .bus_drive_en(bus_drive_en), .cmd_drive_en(cmd_drive_en));

// >>> testbench/lbha_arbiter_tb.sv
// Purpose: Self-checking bench of the hold arbiter against a peer model.
// Assumes: Bench inputs change on the falling edge.
// Notes:   A two-cycle bus unit keeps the run short.
`timescale 1ns/1ns
// ==========================================================
// Bench
module lbha_arbiter_tb;
    logic clk, reset_n, arb_master_select, hold_response_enable, ext_access_needed;
    logic ext_cycle_active, ext_cycle_done, want, p_req_n, p_ack_n, hold_ack_n;
    logic hold_ack_oe, bus_request_n, bus_drive_en, cmd_drive_en;
    int   n_errors, tests_run;
    lbha_arbiter #(.UNIT_CYCLES(2)) i_lbha_arbiter (.clk(clk), .reset_n(reset_n),
        .arb_master_select(arb_master_select), .hold_response_enable(hold_response_enable),
        .ext_access_needed(ext_access_needed), .ext_cycle_active(ext_cycle_active),
        .ext_cycle_done(ext_cycle_done), .hold_request_n(p_req_n), .hold_ack_n_in(p_ack_n),
        .hold_ack_n(hold_ack_n), .hold_ack_oe(hold_ack_oe), .bus_request_n(bus_request_n),
        .bus_drive_en(bus_drive_en), .cmd_drive_en(cmd_drive_en), .bus_granted());
    // A released ack pin is pulled up.
    lbha_peer i_lbha_peer (.clk(clk), .reset_n(reset_n), .as_master(!arb_master_select),
        .want(want), .dut_req_n(bus_request_n), .dut_ack_n(hold_ack_oe ? hold_ack_n : 1'b1),
        .req_n(p_req_n), .ack_n(p_ack_n));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(negedge clk)
    begin
        ext_cycle_done   <= ext_cycle_active;
        ext_cycle_active <= bus_drive_en && ext_access_needed && !ext_cycle_active;
    end
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic t_slave();
        arb_master_select = 1'b0;
        hold_response_enable = 1'b1;
        repeat (20) @(negedge clk);
        ext_access_needed = 1'b1;
        for (int i = 0; i < 60 && bus_drive_en !== 1'b1; i++) @(negedge clk);
        check({bus_request_n, p_ack_n, bus_drive_en}, 4'h1);
        want = 1'b1;
        for (int i = 0; i < 60 && bus_request_n !== 1'b1; i++) @(negedge clk);
        check({bus_drive_en, cmd_drive_en}, 4'h0);
        for (int i = 0; i < 6; i++)
        begin
            @(negedge clk);
            check(bus_request_n | p_req_n, 4'h1);
        end
        // Let the slave own the bus once more, then push it back into hold.
        want = 1'b0;
        for (int i = 0; i < 60 && bus_drive_en !== 1'b1; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        ext_access_needed = 1'b0;
        want = 1'b1;
        for (int i = 0; i < 60 && bus_request_n !== 1'b1; i++) @(negedge clk);
        check({bus_request_n, bus_drive_en}, 4'h2);
        want = 1'b0;
        repeat (20) @(negedge clk);
    endtask
    task automatic t_master();
        arb_master_select = 1'b1;
        want = 1'b1;
        for (int i = 0; i < 60 && hold_ack_n !== 1'b0; i++) @(negedge clk);
        check({hold_ack_oe, bus_drive_en, cmd_drive_en, bus_request_n}, 4'h9);
        repeat (10) @(negedge clk);
        check({hold_ack_n, bus_request_n}, 4'h1);
        ext_access_needed = 1'b1;
        for (int i = 0; i < 60 && hold_ack_n !== 1'b1; i++) @(negedge clk);
        check(bus_drive_en, 4'h1);
        repeat (4) @(negedge clk);
        check(bus_request_n, 4'h1);
    endtask
    task automatic t_disabled();
        want = 1'b0;
        repeat (60) @(negedge clk);
        hold_response_enable = 1'b0;
        want = 1'b1;
        repeat (40) @(negedge clk);
        check({hold_ack_oe, hold_ack_n, bus_drive_en}, 4'h7);
        hold_response_enable = 1'b1;
        for (int i = 0; i < 60 && hold_ack_n !== 1'b0; i++) @(negedge clk);
        check(hold_ack_n, 4'h0);
    endtask
    initial
    begin
        {n_errors, tests_run} = 0;
        {want, ext_access_needed, ext_cycle_active, ext_cycle_done} = 4'h0;
        {arb_master_select, hold_response_enable, reset_n} = 3'h0;
        repeat (8) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        check({hold_ack_oe, bus_request_n, bus_drive_en}, 4'h2);
        t_slave();
        t_master();
        t_disabled();
        complete_run();
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule

// >>> testbench/lbha_peer.sv
// Purpose: Model of the second controller that shares the bus.
// Assumes: Master role while as_master is high, slave role otherwise.
// Notes:   A request must stand DLY cycles before an ack, so a short glitch is ignored.
`timescale 1ns/1ns
// ==========================================================
// Peer controller
module lbha_peer #(parameter int DLY = 6)
(
    // Clock, reset, role and bus want.
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic as_master,
    input  wire logic want,
    // Pins from the block.
    input  wire logic dut_req_n,
    input  wire logic dut_ack_n,
    // Pins to the block.
    output logic      req_n,
    output logic      ack_n
);
    logic [3:0] cnt;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_n <= 1'b1;
            ack_n <= 1'b1;
            cnt   <= 4'h0;
        end
        else
        begin
            cnt <= (as_master && ack_n && dut_req_n) ? 4'h0 : cnt + 4'h1;
            if (as_master && ack_n && !req_n)
                req_n <= 1'b1;
            else if (as_master && ack_n && !dut_req_n && cnt >= DLY)
                ack_n <= 1'b0;
            else if (as_master && !ack_n && dut_req_n)
                ack_n <= 1'b1;
            else if (as_master && !ack_n && want && cnt >= 2)
                req_n <= 1'b0;
            else if (!as_master && req_n && dut_req_n && want && cnt >= DLY)
                req_n <= 1'b0;
            else if (!as_master && !req_n && !dut_ack_n && !dut_req_n)
                req_n <= 1'b1;
        end
    end
endmodule
